// ---- logic/bboe_map.svh ----
`ifndef BBOE_MAP_SVH
`define BBOE_MAP_SVH

// Register byte offsets
`define BBOE_OFS_CTRL      8'h00
`define BBOE_OFS_INSN      8'h04
`define BBOE_OFS_PC        8'h08
`define BBOE_OFS_SP        8'h0c
`define BBOE_OFS_IX        8'h10
`define BBOE_OFS_ACC       8'h14
`define BBOE_OFS_CCR       8'h18
`define BBOE_OFS_STATUS    8'h1c

// Control and status field positions
`define BBOE_CTRL_GO       0
`define BBOE_CTRL_CLR_DONE 1
`define BBOE_STAT_BUSY     0
`define BBOE_STAT_DONE     1
`define BBOE_STAT_ILLEGAL  2

// Condition code bit positions
`define BBOE_CCR_H         5
`define BBOE_CCR_I         4
`define BBOE_CCR_N         3
`define BBOE_CCR_Z         2
`define BBOE_CCR_V         1
`define BBOE_CCR_C         0

// Reset values
`define BBOE_PC_RST        16'h0000
`define BBOE_SP_RST        16'h00ff
`define BBOE_CCR_RST       6'h10

// Opcodes with a fixed meaning
`define BBOE_OP_BRA        8'h20
`define BBOE_OP_BRN        8'h21
`define BBOE_OP_BSR        8'h8d
`define BBOE_OP_SINGLE_BIT_SET_DIR   8'h72
`define BBOE_OP_SINGLE_BIT_SET_IDX   8'h62
`define BBOE_OP_SINGLE_BIT_TOGGLE_DIR   8'h75
`define BBOE_OP_SINGLE_BIT_TOGGLE_IDX   8'h65
`define BBOE_OP_SINGLE_BIT_TEST_DIR   8'h7b
`define BBOE_OP_SINGLE_BIT_TEST_IDX   8'h6b

// Cycle counts
`define BBOE_CYC_IMM       3'd2
`define BBOE_CYC_DIR       3'd3
`define BBOE_CYC_EXT       3'd4
`define BBOE_CYC_IDX       3'd4
`define BBOE_CYC_REL       3'd3
`define BBOE_CYC_BSR       3'd5
`define BBOE_CYC_RMW_DIR   3'd6
`define BBOE_CYC_RMW_IDX   3'd7
`define BBOE_CYC_TST_DIR   3'd4
`define BBOE_CYC_TST_IDX   3'd5

// Branch base offset
`define BBOE_REL_BASE      16'h0002

`endif

// ---- logic/bboe_pkg.sv ----
package bboe_pkg;

    typedef enum logic [2:0] {
        CL_NONE, CL_BRANCH, CL_BSR, CL_BITTEST, CL_SINGLE_BIT_SET, CL_SINGLE_BIT_TOGGLE, CL_SINGLE_BIT_TEST
    } bboe_cls_type;

    typedef enum logic [2:0] {
        MD_IMM, MD_DIR, MD_EXT, MD_IDX, MD_REL
    } bboe_mode_type;

    typedef enum logic [0:0] {
        ST_IDLE, ST_EXEC
    } bboe_fsm_type;

    typedef struct packed {
        bboe_cls_type  cls;
        bboe_mode_type mode;
        logic          acc_b;
        logic [2:0]    cycles;
        logic [1:0]    length;
    } bboe_dec_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } bboe_mem_type;

endpackage

// ---- logic/bboe_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bboe_map.svh"

module bboe_alu
(
    input  wire logic [7:0]          opcode,
    input  wire bboe_pkg::bboe_cls_type cls,
    input  wire logic                use_b,
    input  wire logic [7:0]          acc_a,
    input  wire logic [7:0]          acc_b,
    input  wire logic [7:0]          oper,
    input  wire logic [7:0]          mask,
    input  wire logic [5:0]          ccr_in,
    output logic [7:0]               result,
    output logic [5:0]               ccr_out,
    output logic                     take
);

    logic n;
    logic z;
    logic v;
    logic c;

    always_comb
    begin
        n = ccr_in[`BBOE_CCR_N];
        z = ccr_in[`BBOE_CCR_Z];
        v = ccr_in[`BBOE_CCR_V];
        c = ccr_in[`BBOE_CCR_C];
        result  = 8'h00;
        ccr_out = ccr_in;
        take    = 1'b0;
        case (cls)
            bboe_pkg::CL_BITTEST:
                result = (use_b ? acc_b : acc_a) & oper;
            bboe_pkg::CL_SINGLE_BIT_SET:
                result = oper | mask;
            bboe_pkg::CL_SINGLE_BIT_TOGGLE:
                result = oper ^ mask;
            bboe_pkg::CL_SINGLE_BIT_TEST:
                result = oper & mask;
            bboe_pkg::CL_BSR:
                take = 1'b1;
            bboe_pkg::CL_BRANCH:
                case (opcode[3:0])
                    4'h0: take = 1'b1;
                    4'h1: take = 1'b0;
                    4'h2: take = ~(c | z);
                    4'h3: take = c | z;
                    4'h4: take = ~c;
                    4'h5: take = c;
                    4'h6: take = ~z;
                    4'h7: take = z;
                    4'h8: take = ~v;
                    4'h9: take = v;
                    4'ha: take = ~n;
                    4'hb: take = n;
                    4'hc: take = ~(n ^ v);
                    4'hd: take = n ^ v;
                    4'he: take = ~(z | (n ^ v));
                    default: take = z | (n ^ v);
                endcase
            default:
                take = 1'b0;
        endcase
        // H, I and C are kept; branches keep every flag
        if (cls == bboe_pkg::CL_BITTEST || cls == bboe_pkg::CL_SINGLE_BIT_SET ||
            cls == bboe_pkg::CL_SINGLE_BIT_TOGGLE || cls == bboe_pkg::CL_SINGLE_BIT_TEST)
        begin
            ccr_out[`BBOE_CCR_N] = result[7];
            ccr_out[`BBOE_CCR_Z] = (result == 8'h00);
            ccr_out[`BBOE_CCR_V] = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- logic/bboe_core.sv ----
// What this block does
// - Accumulator bit test only updates flags
// - Bit test: N=R7, Z=zero, V cleared
// - Taken branch: PC plus two plus offset
// - 2F branches on Z or N xor V
// - 23 branches on C or Z
// - 2D branches on N xor V
// - 2B branches on N set
// - 26 branches on Z clear
// - 2A branches on N clear
// - 20 always branches
// - 21 never branches, three cycles
// - 8D pushes return address, then branches
// - Bit set: OR mask, write back
// - Bit toggle: XOR mask, write back
// - Bit test: AND mask, no write
// - Single-bit ops: N=R7, Z=zero, V cleared
// - Three bytes: opcode, one-hot mask, address
// - Indexed single-bit test 6B, five cycles
`timescale 1ns/1ps
`default_nettype none
`include "bboe_map.svh"

module bboe_core
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output bboe_pkg::bboe_mem_type    mem_out,
    input  wire logic [7:0]           mem_rdata
);

    typedef struct packed {
        bboe_pkg::bboe_fsm_type fsm;
        logic [2:0]             step;
        bboe_pkg::bboe_dec_type dec;
        logic [23:0]            insn;
        logic [15:0]            pc;
        logic [15:0]            sp;
        logic [15:0]            ix;
        logic [7:0]             acc_a;
        logic [7:0]             acc_b;
        logic [5:0]             ccr;
        logic [7:0]             oper;
        logic [15:0]            addr;
        logic                   done;
        logic                   illegal;
        bboe_pkg::bboe_mem_type mem;
        logic                   awready;
        logic                   wready;
        logic                   aw_have;
        logic                   w_have;
        logic [7:0]             aw_addr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } bboe_state_type;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    bboe_state_type st_ff;
    bboe_state_type nxt_st;
    logic [7:0]     alu_result;
    logic [5:0]     alu_ccr;
    logic           alu_take;
    logic [15:0]    ret_addr;
    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, data, input logic [3:0] strb);
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (data & bm) | (old & ~bm);
    endfunction
    function automatic bboe_pkg::bboe_dec_type decode(input logic [7:0] op);
        bboe_pkg::bboe_dec_type d;
        d.cls    = bboe_pkg::CL_BITTEST;
        d.acc_b  = op[6];
        d.length = 2'd2;
        d.mode   = bboe_pkg::MD_IMM;
        d.cycles = `BBOE_CYC_IMM;
        casez (op)
            8'h85, 8'hc5: d.mode = bboe_pkg::MD_IMM;
            8'h95, 8'hd5:
            begin
                d.mode   = bboe_pkg::MD_DIR;
                d.cycles = `BBOE_CYC_DIR;
            end
            8'hb5, 8'hf5:
            begin
                d.mode   = bboe_pkg::MD_EXT;
                d.cycles = `BBOE_CYC_EXT;
                d.length = 2'd3;
            end
            8'ha5, 8'he5:
            begin
                d.mode   = bboe_pkg::MD_IDX;
                d.cycles = `BBOE_CYC_IDX;
            end
            `BBOE_OP_BSR:
            begin
                d.cls    = bboe_pkg::CL_BSR;
                d.mode   = bboe_pkg::MD_REL;
                d.cycles = `BBOE_CYC_BSR;
            end
            `BBOE_OP_SINGLE_BIT_SET_DIR, `BBOE_OP_SINGLE_BIT_SET_IDX,
            `BBOE_OP_SINGLE_BIT_TOGGLE_DIR, `BBOE_OP_SINGLE_BIT_TOGGLE_IDX:
            begin
                d.cls    = op[0] ? bboe_pkg::CL_SINGLE_BIT_TOGGLE : bboe_pkg::CL_SINGLE_BIT_SET;
                d.mode   = op[4] ? bboe_pkg::MD_DIR : bboe_pkg::MD_IDX;
                d.cycles = op[4] ? `BBOE_CYC_RMW_DIR : `BBOE_CYC_RMW_IDX;
                d.length = 2'd3;
            end
            `BBOE_OP_SINGLE_BIT_TEST_DIR, `BBOE_OP_SINGLE_BIT_TEST_IDX:
            begin
                d.cls    = bboe_pkg::CL_SINGLE_BIT_TEST;
                d.mode   = op[4] ? bboe_pkg::MD_DIR : bboe_pkg::MD_IDX;
                d.cycles = op[4] ? `BBOE_CYC_TST_DIR : `BBOE_CYC_TST_IDX;
                d.length = 2'd3;
            end
            8'b0010_????:
            begin
                d.cls    = bboe_pkg::CL_BRANCH;
                d.mode   = bboe_pkg::MD_REL;
                d.cycles = `BBOE_CYC_REL;
            end
            default:
                d.cls = bboe_pkg::CL_NONE;
        endcase
        return d;
    endfunction
    // Effective operand address
    function automatic logic [15:0] ea
    (
        input bboe_pkg::bboe_dec_type d,
        input logic [23:0]            insn,
        input logic [15:0]            ix
    );
        logic [7:0] b;
        b = (d.cls == bboe_pkg::CL_BITTEST) ? insn[15:8] : insn[23:16];
        case (d.mode)
            bboe_pkg::MD_EXT: return {insn[15:8], insn[23:16]};
            bboe_pkg::MD_IDX: return ix + {8'h00, b};
            default:          return {8'h00, b};
        endcase
    endfunction
    function automatic logic [31:0] read_reg
    (
        input bboe_state_type s,
        input logic [7:0]     a
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            `BBOE_OFS_INSN:   r = {8'h00, s.insn};
            `BBOE_OFS_PC:     r = {16'h0000, s.pc};
            `BBOE_OFS_SP:     r = {16'h0000, s.sp};
            `BBOE_OFS_IX:     r = {16'h0000, s.ix};
            `BBOE_OFS_ACC:    r = {16'h0000, s.acc_b, s.acc_a};
            `BBOE_OFS_CCR:    r = {26'h0000000, s.ccr};
            `BBOE_OFS_STATUS:
            begin
                r[`BBOE_STAT_BUSY]    = (s.fsm == bboe_pkg::ST_EXEC);
                r[`BBOE_STAT_DONE]    = s.done;
                r[`BBOE_STAT_ILLEGAL] = s.illegal;
                r[10:8]               = s.step;
            end
            default:          r = 32'h0000_0000;
        endcase
        return r;
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= `BBOE_OFS_STATUS);
    endfunction
    bboe_alu u_alu
    (
        .opcode  (st_ff.insn[7:0]),
        .cls     (st_ff.dec.cls),
        .use_b   (st_ff.dec.acc_b),
        .acc_a   (st_ff.acc_a),
        .acc_b   (st_ff.acc_b),
        .oper    (st_ff.oper),
        .mask    (st_ff.insn[15:8]),
        .ccr_in  (st_ff.ccr),
        .result  (alu_result),
        .ccr_out (alu_ccr),
        .take    (alu_take)
    );
    assign ret_addr = st_ff.pc + `BBOE_REL_BASE;
    always_comb
    begin
        logic        wr_go;
        logic        busy;
        logic [31:0] w;
        wr_go  = 1'b0;
        busy   = (st_ff.fsm == bboe_pkg::ST_EXEC);
        w      = 32'h0000_0000;
        nxt_st = st_ff;
        nxt_st.mem.rd = 1'b0;
        nxt_st.mem.wr = 1'b0;
        // Write channel: address and data in either order
        if (s_axi_awvalid && st_ff.awready)
        begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready)
        begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid)
        begin
            {nxt_st.aw_have, nxt_st.w_have} = 2'b00;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = mapped(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            w = merge(read_reg(st_ff, st_ff.aw_addr), st_ff.wdata, st_ff.wstrb);
            if (st_ff.aw_addr == `BBOE_OFS_CTRL && st_ff.wstrb[0])
            begin
                wr_go = w[`BBOE_CTRL_GO];
                if (w[`BBOE_CTRL_CLR_DONE])
                begin
                    nxt_st.done    = 1'b0;
                    nxt_st.illegal = 1'b0;
                end
            end
            if (!busy)
            begin
                case (st_ff.aw_addr)
                    `BBOE_OFS_INSN: nxt_st.insn = w[23:0];
                    `BBOE_OFS_PC:   nxt_st.pc = w[15:0];
                    `BBOE_OFS_SP:   nxt_st.sp = w[15:0];
                    `BBOE_OFS_IX:   nxt_st.ix = w[15:0];
                    `BBOE_OFS_ACC:  {nxt_st.acc_b, nxt_st.acc_a} = w[15:0];
                    `BBOE_OFS_CCR:  nxt_st.ccr = w[5:0];
                    default:        ;
                endcase
            end
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid  = 1'b0;
            {nxt_st.awready, nxt_st.wready} = 2'b11;
        end
        // Read channel
        if (s_axi_arvalid && st_ff.arready)
        begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rdata   = read_reg(st_ff, s_axi_araddr);
            nxt_st.rresp   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // Execution engine; its set of done wins over a clear
        case (st_ff.fsm)
            bboe_pkg::ST_IDLE:
            begin
                if (wr_go)
                begin
                    nxt_st.dec  = decode(st_ff.insn[7:0]);
                    nxt_st.oper = st_ff.insn[15:8];
                    nxt_st.step = 3'd1;
                    nxt_st.fsm  = bboe_pkg::ST_EXEC;
                    if (nxt_st.dec.cls == bboe_pkg::CL_NONE)
                    begin
                        nxt_st.illegal = 1'b1;
                        nxt_st.done    = 1'b1;
                        nxt_st.fsm     = bboe_pkg::ST_IDLE;
                    end
                end
            end
            bboe_pkg::ST_EXEC:
            begin
                nxt_st.step = st_ff.step + 3'd1;
                if (st_ff.dec.cls == bboe_pkg::CL_BSR && st_ff.step <= 3'd2)
                begin
                    nxt_st.mem.addr  = st_ff.sp;
                    nxt_st.mem.wdata = st_ff.step[0] ? ret_addr[7:0] : ret_addr[15:8];
                    nxt_st.mem.wr    = 1'b1;
                    nxt_st.sp        = st_ff.sp - 16'h0001;
                end
                if (st_ff.step == 3'd1)
                begin
                    nxt_st.addr = ea(st_ff.dec, st_ff.insn, st_ff.ix);
                    if (st_ff.dec.mode != bboe_pkg::MD_IMM &&
                        st_ff.dec.mode != bboe_pkg::MD_REL)
                    begin
                        nxt_st.mem.addr = nxt_st.addr;
                        nxt_st.mem.rd   = 1'b1;
                    end
                end
                if (st_ff.step == 3'd2 && st_ff.mem.rd)
                begin
                    nxt_st.oper = mem_rdata;
                end
                if (st_ff.step == 3'd3 && (st_ff.dec.cls == bboe_pkg::CL_SINGLE_BIT_SET ||
                    st_ff.dec.cls == bboe_pkg::CL_SINGLE_BIT_TOGGLE))
                begin
                    nxt_st.mem.addr  = st_ff.addr;
                    nxt_st.mem.wdata = alu_result;
                    nxt_st.mem.wr    = 1'b1;
                end
                if (st_ff.step == st_ff.dec.cycles)
                begin
                    nxt_st.fsm  = bboe_pkg::ST_IDLE;
                    nxt_st.done = 1'b1;
                    nxt_st.ccr  = alu_ccr;
                    nxt_st.pc = alu_take
                        ? ret_addr + {{8{st_ff.insn[15]}}, st_ff.insn[15:8]}
                        : st_ff.pc + {14'h0000, st_ff.dec.length};
                end
            end
            default:
                nxt_st.fsm = bboe_pkg::ST_IDLE;
        endcase
        if (!aresetn)
        begin
            nxt_st         = '0;
            nxt_st.pc      = `BBOE_PC_RST;
            nxt_st.sp      = `BBOE_SP_RST;
            nxt_st.ccr     = `BBOE_CCR_RST;
            {nxt_st.awready, nxt_st.wready, nxt_st.arready} = 3'b111;
        end
    end
    always_ff @(posedge aclk)
    begin
        st_ff <= nxt_st;
    end
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign mem_out       = st_ff.mem;
endmodule
`default_nettype wire

// ---- verification/bboe_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module bboe_props
(
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [7:0]             s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic [31:0]            s_axi_wdata,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire bboe_pkg::bboe_mem_type mem_out,
    input wire logic [7:0]             mem_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [23:0] insn_ff;
    logic [7:0]  op;
    logic        wr_both;
    assign op = insn_ff[7:0];
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // Shadow of the instruction word last written
    always_ff @(posedge aclk)
    begin
        if (wr_both && s_axi_awaddr == 8'h04)
            insn_ff <= s_axi_wdata[23:0];
    end
    sequence s_set;
        ##2 (mem_out.wr && mem_out.wdata == ($past(mem_rdata, 2) | insn_ff[15:8]));
    endsequence
    sequence s_tgl;
        ##2 (mem_out.wr && mem_out.wdata == ($past(mem_rdata, 2) ^ insn_ff[15:8]));
    endsequence
    chk_write_answer :
        assert property (wr_both |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    chk_bvalid_hold :
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_read_answer :
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read response");
    chk_err_zero :
        assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    chk_no_write :
        assert property (op[7] && op[3:0] == 4'h5 || op == 8'h7b || op == 8'h6b |-> !mem_out.wr)
        else $error("test wrote memory");
    chk_branch_quiet :
        assert property (op[7:4] == 4'h2 |-> !mem_out.rd && !mem_out.wr)
        else $error("branch touched memory");
    chk_push_order :
        assert property (mem_out.wr && $past(mem_out.wr) |-> mem_out.addr == $past(mem_out.addr) - 16'h1)
        else $error("push address not decremented");
    chk_set_merge :
        assert property ((op == 8'h72 || op == 8'h62) && mem_out.rd |-> s_set)
        else $error("bit set write-back wrong");
    chk_tgl_merge :
        assert property ((op == 8'h75 || op == 8'h65) && mem_out.rd |-> s_tgl)
        else $error("bit toggle write-back wrong");
    chk_dir_addr :
        assert property ((op == 8'h72 || op == 8'h75 || op == 8'h7b) && mem_out.rd
            |-> mem_out.addr == {8'h00, insn_ff[23:16]}) else $error("direct address wrong");
endmodule
bind bboe_core bboe_props chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mem_out,
    .mem_rdata);
`default_nettype wire

// ---- verification/bboe_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bboe_mem_model
(
    input  wire logic                   aclk,
    input  wire bboe_pkg::bboe_mem_type mem_out,
    output logic [7:0]                  mem_rdata
);
    logic [7:0] mem_ff [0:65535];
    // Outside a read the bus shows the inverse, so stale data cannot pass
    assign mem_rdata = mem_out.rd ? mem_ff[mem_out.addr] : ~mem_ff[mem_out.addr];
    always @(posedge aclk)
    begin
        if (mem_out.wr)
            mem_ff[mem_out.addr] <= mem_out.wdata;
    end
endmodule
`default_nettype wire

// ---- verification/bboe_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bboe_core_tb;
    logic                   aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]             s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, mem_rdata;
    logic [31:0]            s_axi_wdata = 32'h0, rv = 32'h0, s_axi_rdata;
    logic [3:0]             s_axi_wstrb = 4'hf;
    logic                   s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic                   s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]             s_axi_bresp, s_axi_rresp, resp;
    bboe_pkg::bboe_mem_type mem_out;
    int                     cyc = 0, err_total = 0, total_checks = 0;
    bboe_core dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mem_out, .mem_rdata);
    bboe_mem_model mem_u (.aclk, .mem_out, .mem_rdata);
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    task automatic close_out;
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready && s_axi_wvalid)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        wr_reg(a, d, resp);
    endtask
    task automatic look(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, rv, resp);
        chk(rv, exp);
    endtask
    task automatic run(input logic [23:0] insn);
        put(8'h04, {8'h00, insn});
        put(8'h00, 32'h1);
        rv = 32'h0;
        for (int n = 0; n < 20 && rv[1] !== 1'h1; n++)
            rd_reg(8'h1c, rv, resp);
        chk(rv[2:0], 3'h2);
        put(8'h00, 32'h2);
    endtask
    task automatic t_reset;
        look(8'h08, 32'h0);
        look(8'h0c, 32'h00ff);
        look(8'h18, 32'h10);
        rd_reg(8'h40, rv, resp);
        chk(rv, 32'h0);
        chk(resp, 2'h2);
        wr_reg(8'h40, 32'h5, resp);
        chk(resp, 2'h2);
    endtask
    task automatic t_branch;
        logic [16:0] tab [16] = '{17'h12f04, 17'h02f0a, 17'h12f08, 17'h12301, 17'h02300,
            17'h12304, 17'h12d02, 17'h02d0a, 17'h12b08, 17'h02b00, 17'h12600, 17'h02604,
            17'h12a00, 17'h02a08, 17'h1203f, 17'h0213f};
        foreach (tab[i])
        begin
            put(8'h08, 32'h0100);
            put(8'h18, {24'h0, tab[i][7:0]});
            run({8'h00, 8'hf0, tab[i][15:8]});
            look(8'h08, tab[i][16] ? 32'h00f2 : 32'h0102);
            look(8'h18, {24'h0, tab[i][7:0]});
        end
    endtask
    task automatic t_bsr;
        put(8'h08, 32'h1234);
        put(8'h0c, 32'h0080);
        put(8'h18, 32'h0a);
        run(24'h00108d);
        look(8'h08, 32'h1246);
        look(8'h0c, 32'h007e);
        chk({mem_u.mem_ff[16'h007f], mem_u.mem_ff[16'h0080]}, 16'h1236);
        look(8'h18, 32'h0a);
    endtask
    task automatic t_bittest;
        logic [31:0] tab [8] = '{32'h85800035, 32'h95400035, 32'hb5124031, 32'ha5100035,
            32'hc5800039, 32'hd5400039, 32'hf5124035, 32'he5100039};
        mem_u.mem_ff[16'h0040] = 8'h80;
        mem_u.mem_ff[16'h1240] = 8'h01;
        put(8'h10, 32'h0030);
        put(8'h14, 32'hf00f);
        foreach (tab[i])
        begin
            put(8'h18, 32'h33);
            run({tab[i][15:8], tab[i][23:16], tab[i][31:24]});
            look(8'h18, {24'h0, tab[i][7:0]});
            look(8'h14, 32'hf00f);
        end
        chk(mem_u.mem_ff[16'h0040], 8'h80);
    endtask
    task automatic t_single;
        logic [39:0] tab [6] = '{40'h7280008039, 40'h6201101131, 40'h7501010035,
            40'h6580810131, 40'h7b80808039, 40'h6b02fdfd35};
        put(8'h10, 32'h0030);
        foreach (tab[i])
        begin
            mem_u.mem_ff[16'h0050] = tab[i][23:16];
            put(8'h18, 32'h33);
            run({tab[i][36] ? 8'h50 : 8'h20, tab[i][31:24], tab[i][39:32]});
            chk(mem_u.mem_ff[16'h0050], tab[i][15:8]);
            look(8'h18, {24'h0, tab[i][7:0]});
        end
    endtask
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_branch();
        t_bsr();
        t_bittest();
        t_single();
        close_out();
    end
endmodule
`default_nettype wire
